// [dv/irl_core_model.sv]
// Core model: takes offered vectors after a chosen number of cycles.
// Assumes vecReq and vecIdx stand until vecAck is seen high at an edge.
`timescale 1ns/100ps

module irl_core_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Vector hand-off
   input  wire logic       vecReq,
   output      logic       vecAck,
   // Pace of answers
   input  wire logic [3:0] ackDelay
);
   logic [3:0] waitCnt;

   // One-cycle ack, never while nothing is offered, so no vector is taken twice
   always_ff @(posedge clk_sys) begin
      if (!rst_n || vecAck || !vecReq) begin
         vecAck  <= 1'b0;
         waitCnt <= 4'h0;
      end else if (waitCnt >= ackDelay) begin
         vecAck <= 1'b1;
      end else begin
         waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule

// [dv/test_irl_request_latch.sv]
// Self-checking bench for the request latch, with a core model on the vector side.
// Assumes irl_pkg is compiled first and irl_defs.svh is on the include path.
`timescale 1ns/100ps
`include "irl_defs.svh"

module test_irl_request_latch import irl_pkg::*;;
   localparam logic [13:0] G0 = `IRL_BYTE_ADDR(`IRL_GRP0_IDX);
   localparam logic [13:0] G1 = `IRL_BYTE_ADDR(`IRL_GRP1_IDX);
   localparam logic [13:0] ES = `IRL_BYTE_ADDR(`IRL_EDGESEL_IDX);
   localparam logic [13:0] AE = `IRL_BYTE_ADDR(`IRL_ANYEDGE_IDX);
   localparam logic [13:0] CT = `IRL_BYTE_ADDR(`IRL_CTRL_IDX);
   localparam logic [13:0] ST = `IRL_BYTE_ADDR(`IRL_ISTAT_IDX);
   localparam logic [13:0] MK = `IRL_BYTE_ADDR(`IRL_IMASK_IDX);
   localparam logic [1:0]  OK = `IRL_RESP_OKAY;
   localparam logic [1:0]  ER = `IRL_RESP_SLVERR;

   logic        clk_sys = 1'b0;
   logic        rst_n;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, vecIdx, ackDelay;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        timerOneReq, timerZeroReq, serialRxReq, serialTxReq, converterReq, comparatorReq, pin7SharedReq;
   logic [7:0]  portAPin, es, ae;
   logic        vecReq, vecAck, wdtTrapReq, oscPrimFailReq, oscWdtFailReq, irq;
   logic [2:0]  trapOut, tv;
   logic [33:0] rq[$];
   logic [1:0]  wq[$];
   logic [3:0]  vq[$];
   int          bits[5] = '{0, 3, 4, 5, 6};
   int          miscompares = 0;
   int          checks_done = 0;
   int          seed = 94917;
   int          n;

   irl_request_latch dut (.*);
   irl_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .vecReq(vecReq), .vecAck(vecAck), .ackDelay(ackDelay));

   always #12.5 clk_sys = ~clk_sys;

   task automatic give_verdict();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hang(input string nm);
      miscompares++;
      $display("[ERR] %s expected answer seen timeout", nm);
      give_verdict();
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
      int k;
      k = 0;
      wq.push_back(r);
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         k++;
      end while (s_axi_bvalid !== 1'b1 && k < 40);
      s_axi_bready <= 1'b0;
      if (k >= 40) hang("bvalid");
   endtask

   task automatic rd(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
      int k;
      k = 0;
      rq.push_back({r, 24'h0, d});
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         k++;
      end while (s_axi_rvalid !== 1'b1 && k < 40);
      s_axi_rready <= 1'b0;
      if (k >= 40) hang("rvalid");
   endtask

   task automatic src(input logic [4:0] v);
      @(posedge clk_sys) {timerOneReq, timerZeroReq, serialRxReq, serialTxReq, converterReq} <= v;
      @(posedge clk_sys) {timerOneReq, timerZeroReq, serialRxReq, serialTxReq, converterReq} <= 5'h0;
   endtask

   // Answers are compared against the oldest note when they appear
   always @(posedge clk_sys) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready && rq.size() > 0) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid === 1'b1 && s_axi_bready && wq.size() > 0) chk("bresp", 34'(wq.pop_front()), 34'(s_axi_bresp));
      if (vecReq === 1'b1 && vecAck === 1'b1 && vq.size() > 0) chk("vecIdx", 34'(vq.pop_front()), 34'(vecIdx));
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      hang("run");
   end

   initial begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
      s_axi_wstrb = 4'h1;
      {timerOneReq, timerZeroReq, serialRxReq, serialTxReq, converterReq, comparatorReq, pin7SharedReq} = 7'h0;
      {portAPin, oscWdtFailReq, oscPrimFailReq, wdtTrapReq, ackDelay} = 15'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(G0, 8'h00, OK);
      rd(G1, 8'h00, OK);
      rd(14'h3ffc, 8'h00, ER);
      rd(G0 | 14'h1, 8'h00, ER);
      wr(14'h3ffc, 8'h5a, ER);
      for (int i = 0; i < 5; i++) begin
         src(5'h1 << i);
         rd(G0, 8'h1 << bits[i], OK);
         chk("vecReq", 34'h0, 34'(vecReq));
         wr(G0, 8'h00, OK);
      end
      chk("irq", 34'h0, 34'(irq));
      wr(MK, 8'h01, OK);
      repeat (2) @(posedge clk_sys);
      chk("irq", 34'h1, 34'(irq));
      rd(ST, 8'h01, OK);
      wr(ST, 8'h01, OK);
      repeat (2) @(posedge clk_sys);
      chk("irq", 34'h0, 34'(irq));
      // A held request must survive a clearing write
      @(posedge clk_sys) timerZeroReq <= 1'b1;
      wr(G0, 8'h00, OK);
      @(posedge clk_sys) timerZeroReq <= 1'b0;
      rd(G0, 8'h20, OK);
      wr(G0, 8'h00, OK);
      wr(ST, 8'h03, OK);
      es = 8'($random(seed));
      ae = 8'($random(seed));
      wr(ES, es, OK);
      rd(ES, es, OK);
      wr(AE, ae, OK);
      @(posedge clk_sys) portAPin <= 8'hff;
      repeat (8) @(posedge clk_sys);
      rd(G1, es | ae, OK);
      wr(G1, 8'h00, OK);
      @(posedge clk_sys) portAPin <= 8'h00;
      repeat (8) @(posedge clk_sys);
      rd(G1, ~es | ae, OK);
      chk("irq", 34'h0, 34'(irq));
      wr(G1, 8'h00, OK);
      @(posedge clk_sys) {pin7SharedReq, comparatorReq} <= 2'b11;
      @(posedge clk_sys) {pin7SharedReq, comparatorReq} <= 2'b00;
      rd(G1, 8'hc0, OK);
      wr(G1, 8'h00, OK);
      s_axi_wstrb <= 4'h0;
      wr(G1, 8'hff, OK);
      s_axi_wstrb <= 4'h1;
      rd(G1, 8'h00, OK);
      wr(MK, 8'h00, OK);
      wr(CT, 8'h01, OK);
      // Vectors taken first promptly, then by a slow core
      for (int k = 0; k < 2; k++) begin
         ackDelay <= k ? 4'h6 : 4'h0;
         vq.push_back(4'he);
         vq.push_back(4'h8);
         vq.push_back(4'h6);
         @(posedge clk_sys) {timerOneReq, converterReq, comparatorReq} <= 3'b111;
         @(posedge clk_sys) {timerOneReq, converterReq, comparatorReq} <= 3'b000;
         n = 0;
         while (vq.size() > 0 && n < 100) begin
            @(posedge clk_sys);
            n++;
         end
         if (n >= 100) hang("vecAck");
         rd(G0, 8'h00, OK);
         rd(G1, 8'h00, OK);
      end
      for (int k = 0; k < 4; k++) begin
         tv = 3'($random(seed));
         @(posedge clk_sys) {oscWdtFailReq, oscPrimFailReq, wdtTrapReq} <= tv;
         repeat (2) @(posedge clk_sys);
         chk("trapOut", 34'(tv), 34'(trapOut));
      end
      @(posedge clk_sys) {oscWdtFailReq, oscPrimFailReq, wdtTrapReq} <= 3'h0;
      repeat (2) @(posedge clk_sys);
      chk("trapOut", 34'h0, 34'(trapOut));
      rd(G0, 8'h00, OK);
      rd(G1, 8'h00, OK);
      give_verdict();
   end
endmodule

// [inc/irl_defs.svh]
// Register indices, field positions and reset values of the request latch.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IRL_DEFS_SVH
`define IRL_DEFS_SVH

`define IRL_ADDR_W        14
`define IRL_GRP0_IDX      12'hfc0
`define IRL_GRP1_IDX      12'hfc3
`define IRL_EDGESEL_IDX   12'hfcd
`define IRL_CTRL_IDX      12'hfe0
`define IRL_ANYEDGE_IDX   12'hfe1
`define IRL_ISTAT_IDX     12'hfe2
`define IRL_IMASK_IDX     12'hfe3
`define IRL_BYTE_ADDR(i)  ({(i), 2'b00})

`define IRL_G0_T1_BIT     6
`define IRL_G0_T0_BIT     5
`define IRL_G0_RX_BIT     4
`define IRL_G0_TX_BIT     3
`define IRL_G0_ADC_BIT    0
`define IRL_G0_RSVD_MASK  8'h86
`define IRL_G1_SHARED_BIT 7
`define IRL_G1_CMP_BIT    6
`define IRL_CTRL_GIE_BIT  0
`define IRL_ST_G0_BIT     0
`define IRL_ST_G1_BIT     1

`define IRL_GRP_RESET     8'h00
`define IRL_CFG_RESET     8'h00
`define IRL_RESP_OKAY     2'b00
`define IRL_RESP_SLVERR   2'b10

`endif

// [inc/irl_pkg.sv]
// Types shared by the request latch, its bus slave and its pin edge stage.
// Assumes irl_defs.svh is reachable on the include path.
`include "irl_defs.svh"

package irl_pkg;

   typedef logic [7:0]               irl_byte_t;
   typedef logic [`IRL_ADDR_W-1:0]   irl_addr_t;

   typedef struct packed {
      logic      awHeld;
      logic      wHeld;
      irl_addr_t wAddr;
      irl_byte_t wData;
      logic      wByte;
      logic      awReady;
      logic      wReady;
      logic      bValid;
      logic [1:0] bResp;
      logic      arReady;
      logic      rPend;
      irl_addr_t rAddr;
      logic      rValid;
      irl_byte_t rData;
      logic [1:0] rResp;
   } irl_axi_s;

   typedef struct packed {
      irl_byte_t sync1;
      irl_byte_t sync2;
      irl_byte_t prev;
      logic [1:0] fill;
   } irl_edge_s;

   typedef struct packed {
      irl_byte_t grp0;
      irl_byte_t grp1;
      irl_byte_t edgeSel;
      irl_byte_t anyEdge;
      logic      gie;
      logic [1:0] status;
      logic [1:0] mask;
      logic      irq;
      logic      vecValid;
      logic [3:0] vecIdx;
      logic [2:0] trap;
   } irl_latch_s;

endpackage

// [rtl/irl_axi_slave.sv]
// AXI4-Lite slave front end: one write and one read at a time, 8-bit registers.
// Assumes the register file decodes rdAddr/wrAddr combinationally.
`timescale 1ns/100ps
`include "irl_defs.svh"

module irl_axi_slave import irl_pkg::*; (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // AXI4-Lite
   input  wire logic [`IRL_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [`IRL_ADDR_W-1:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Register file side
   output      logic        wrEn,
   output      logic        wrFire,
   output      irl_addr_t   wrAddr,
   output      irl_byte_t   wrData,
   input  wire logic        wrErr,
   output      logic        rdFire,
   output      irl_addr_t   rdAddr,
   input  wire irl_byte_t   rdData,
   input  wire logic        rdErr
);

   irl_axi_s st;
   irl_axi_s nx;

   assign wrFire = st.awHeld && st.wHeld && !st.bValid;
   assign wrEn   = wrFire && st.wByte;
   assign wrAddr = st.wAddr;
   assign wrData = st.wData;
   assign rdFire = st.rPend;
   assign rdAddr = st.rAddr;

   always_comb begin
      nx = st;
      if (s_axi_awvalid && st.awReady) begin
         nx.awHeld = 1'b1;
         nx.wAddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wReady) begin
         nx.wHeld = 1'b1;
         nx.wData = s_axi_wdata[7:0];
         nx.wByte = s_axi_wstrb[0];
      end
      if (wrFire) begin
         nx.awHeld = 1'b0;
         nx.wHeld  = 1'b0;
         nx.bValid = 1'b1;
         nx.bResp  = wrErr ? `IRL_RESP_SLVERR : `IRL_RESP_OKAY;
      end else if (st.bValid && s_axi_bready) begin
         nx.bValid = 1'b0;
      end
      nx.awReady = !nx.awHeld && !nx.bValid;
      nx.wReady  = !nx.wHeld && !nx.bValid;
      if (s_axi_arvalid && st.arReady) begin
         nx.rPend = 1'b1;
         nx.rAddr = s_axi_araddr;
      end
      if (rdFire) begin
         nx.rPend  = 1'b0;
         nx.rValid = 1'b1;
         nx.rData  = rdData;
         nx.rResp  = rdErr ? `IRL_RESP_SLVERR : `IRL_RESP_OKAY;
      end else if (st.rValid && s_axi_rready) begin
         nx.rValid = 1'b0;
      end
      nx.arReady = !nx.rPend && !nx.rValid;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign s_axi_awready = st.awReady;
   assign s_axi_wready  = st.wReady;
   assign s_axi_bvalid  = st.bValid;
   assign s_axi_bresp   = st.bResp;
   assign s_axi_arready = st.arReady;
   assign s_axi_rvalid  = st.rValid;
   assign s_axi_rresp   = st.rResp;
   assign s_axi_rdata   = {24'h000000, st.rData};

endmodule

// [rtl/irl_edge_detect.sv]
// Pin synchroniser and per-pin edge selection for the port A requests.
// Assumes pins are asynchronous; the config inputs come from clk_sys logic.
`timescale 1ns/100ps

module irl_edge_detect import irl_pkg::*; #(
   parameter int N = 8
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Pins and configuration
   input  wire logic [N-1:0] pinIn,
   input  wire logic [N-1:0] edgeSel,
   input  wire logic [N-1:0] anyEdge,
   // Detected edges, one-cycle pulses
   output      logic [N-1:0] pinEvent
);

   irl_edge_s st;
   irl_edge_s nx;
   logic      armed;

   always_comb begin
      nx       = st;
      nx.sync1 = pinIn;
      nx.sync2 = st.sync1;
      nx.prev  = st.sync2;
      nx.fill  = (st.fill == 2'h3) ? st.fill : st.fill + 2'h1;
   end

   // A pin already high at reset is no edge: events wait until prev holds a synced value
   assign armed = (st.fill == 2'h3);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   // Only sync2 and prev are looked at, never the first stage
   for (genvar i = 0; i < N; i++) begin : gPin
      logic rise;
      logic fall;
      assign rise = st.sync2[i] & ~st.prev[i];
      assign fall = ~st.sync2[i] & st.prev[i];
      assign pinEvent[i] = armed & (anyEdge[i] ? (rise | fall) : (edgeSel[i] ? rise : fall));

      a_edge_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
         (pinEvent[i] && !anyEdge[i]) |-> (st.sync2[i] == edgeSel[i]) && (st.prev[i] != edgeSel[i]))
         else $error("pin event on the unselected edge");
   end

endmodule

// [rtl/irl_request_latch.sv]
// Interrupt request latch: two pending-request groups, vector hand-off, traps.
// Assumes the core and the peripheral sources run on clk_sys; port pins do not.
`timescale 1ns/100ps
`include "irl_defs.svh"

// Contract
// - A request from timer, UART or ADC sets its bit in group zero.
// - A port A pin event sets that pin's bit in group one.
// - With global enable set, pending requests are offered to the core as vectors.
// - Group zero bits: timer1 6, timer0 5, rx 4, tx 3, converter 0.
// - Group zero at 0xfc0, group one at 0xfc3; both reset to zero.
// - Group one: a bit per pin; bit 7 shared, bit 6 shared with comparator.
// - Each pin requests on one selected edge or on any edge.
// - Watchdog and oscillator-fail traps bypass the request registers.
// - Edge select bit 0 picks the falling edge, 1 the rising edge.
module irl_request_latch import irl_pkg::*; (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // AXI4-Lite
   input  wire logic [`IRL_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [`IRL_ADDR_W-1:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Peripheral request pulses
   input  wire logic        timerOneReq,
   input  wire logic        timerZeroReq,
   input  wire logic        serialRxReq,
   input  wire logic        serialTxReq,
   input  wire logic        converterReq,
   input  wire logic        comparatorReq,
   input  wire logic        pin7SharedReq,
   // Port A pins
   input  wire logic [7:0]  portAPin,
   // Core vector hand-off
   output      logic        vecReq,
   output      logic [3:0]  vecIdx,
   input  wire logic        vecAck,
   // Bypass traps
   input  wire logic        wdtTrapReq,
   input  wire logic        oscPrimFailReq,
   input  wire logic        oscWdtFailReq,
   output      logic [2:0]  trapOut,
   // Summary interrupt
   output      logic        irq
);

   localparam irl_addr_t GRP0_ADDR    = `IRL_BYTE_ADDR(`IRL_GRP0_IDX);
   localparam irl_addr_t GRP1_ADDR    = `IRL_BYTE_ADDR(`IRL_GRP1_IDX);
   localparam irl_addr_t EDGESEL_ADDR = `IRL_BYTE_ADDR(`IRL_EDGESEL_IDX);
   localparam irl_addr_t CTRL_ADDR    = `IRL_BYTE_ADDR(`IRL_CTRL_IDX);
   localparam irl_addr_t ANYEDGE_ADDR = `IRL_BYTE_ADDR(`IRL_ANYEDGE_IDX);
   localparam irl_addr_t ISTAT_ADDR   = `IRL_BYTE_ADDR(`IRL_ISTAT_IDX);
   localparam irl_addr_t IMASK_ADDR   = `IRL_BYTE_ADDR(`IRL_IMASK_IDX);

   irl_latch_s st;
   irl_latch_s nx;

   logic       wrEn;
   logic       wrFire;
   irl_addr_t  wrAddr;
   irl_byte_t  wrData;
   logic       wrErr;
   logic       rdFire;
   irl_addr_t  rdAddr;
   irl_byte_t  rdData;
   logic       rdErr;
   logic [7:0] pinEvent;
   irl_byte_t  setGrp0;
   irl_byte_t  setGrp1;
   irl_byte_t  ackGrp0;
   irl_byte_t  ackGrp1;
   logic [15:0] pendAll;
   logic       ackTaken;
   logic [15:0] pendNow;
   logic [15:0] setAll;

   irl_axi_slave u_axi (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrEn          (wrEn),
      .wrFire        (wrFire),
      .wrAddr        (wrAddr),
      .wrData        (wrData),
      .wrErr         (wrErr),
      .rdFire        (rdFire),
      .rdAddr        (rdAddr),
      .rdData        (rdData),
      .rdErr         (rdErr)
   );

   irl_edge_detect #(.N(8)) u_edge (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pinIn    (portAPin),
      .edgeSel  (st.edgeSel),
      .anyEdge  (st.anyEdge),
      .pinEvent (pinEvent)
   );

   // Set terms per bit
   always_comb begin
      setGrp0 = 8'h00;
      setGrp0[`IRL_G0_T1_BIT]  = timerOneReq;
      setGrp0[`IRL_G0_T0_BIT]  = timerZeroReq;
      setGrp0[`IRL_G0_RX_BIT]  = serialRxReq;
      setGrp0[`IRL_G0_TX_BIT]  = serialTxReq;
      setGrp0[`IRL_G0_ADC_BIT] = converterReq;
      setGrp1 = pinEvent;
      setGrp1[`IRL_G1_SHARED_BIT] = pinEvent[`IRL_G1_SHARED_BIT] | pin7SharedReq;
      setGrp1[`IRL_G1_CMP_BIT]    = pinEvent[`IRL_G1_CMP_BIT] | comparatorReq;
   end

   // The vector taken is the one registered and shown on vecIdx
   assign ackTaken = vecAck && st.vecValid;
   always_comb begin
      ackGrp0 = 8'h00;
      ackGrp1 = 8'h00;
      if (ackTaken && st.vecIdx[3]) begin
         ackGrp0[st.vecIdx[2:0]] = 1'b1;
      end
      if (ackTaken && !st.vecIdx[3]) begin
         ackGrp1[st.vecIdx[2:0]] = 1'b1;
      end
   end

   // Unmapped addresses answer SLVERR
   always_comb begin
      rdErr  = 1'b0;
      rdData = 8'h00;
      case (rdAddr)
         GRP0_ADDR:    rdData = st.grp0;
         GRP1_ADDR:    rdData = st.grp1;
         EDGESEL_ADDR: rdData = st.edgeSel;
         CTRL_ADDR:    rdData = {7'h00, st.gie};
         ANYEDGE_ADDR: rdData = st.anyEdge;
         ISTAT_ADDR:   rdData = {6'h00, st.status};
         IMASK_ADDR:   rdData = {6'h00, st.mask};
         default:      rdErr  = rdFire;
      endcase
   end

   always_comb begin
      case (wrAddr)
         GRP0_ADDR, GRP1_ADDR, EDGESEL_ADDR, CTRL_ADDR, ANYEDGE_ADDR, ISTAT_ADDR, IMASK_ADDR: wrErr = 1'b0;
         default: wrErr = 1'b1;
      endcase
   end

   always_comb begin
      nx = st;
      // A write replaces the value, an ack clears its bit, a new request always wins
      if (wrEn && wrAddr == GRP0_ADDR) begin
         nx.grp0 = wrData;
      end
      if (wrEn && wrAddr == GRP1_ADDR) begin
         nx.grp1 = wrData;
      end
      nx.grp0 = ((nx.grp0 & ~ackGrp0) | setGrp0) & ~`IRL_G0_RSVD_MASK;
      nx.grp1 = (nx.grp1 & ~ackGrp1) | setGrp1;
      if (wrEn && wrAddr == EDGESEL_ADDR) begin
         nx.edgeSel = wrData;
      end
      if (wrEn && wrAddr == ANYEDGE_ADDR) begin
         nx.anyEdge = wrData;
      end
      if (wrEn && wrAddr == CTRL_ADDR) begin
         nx.gie = wrData[`IRL_CTRL_GIE_BIT];
      end
      if (wrEn && wrAddr == IMASK_ADDR) begin
         nx.mask = wrData[1:0];
      end
      if (wrEn && wrAddr == ISTAT_ADDR) begin
         nx.status = st.status & ~wrData[1:0];
      end
      // Sticky event bits; set wins over the write-one clear
      nx.status[`IRL_ST_G0_BIT] = nx.status[`IRL_ST_G0_BIT] | (|setGrp0);
      nx.status[`IRL_ST_G1_BIT] = nx.status[`IRL_ST_G1_BIT] | (|setGrp1);
      nx.irq = |(nx.status & nx.mask);
      // Filled here, not by an assign, so the priority loop reads nothing fed back through nx
      pendAll = {nx.grp0, nx.grp1};
      // Fixed priority, group zero bit 6 highest; with gie clear nothing is offered
      nx.vecValid = 1'b0;
      nx.vecIdx   = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (nx.gie && pendAll[i]) begin
            nx.vecValid = 1'b1;
            nx.vecIdx   = 4'(i);
         end
      end
      // Traps only retime; they never touch the request groups
      nx.trap = {oscWdtFailReq, oscPrimFailReq, wdtTrapReq};
   end

   // Flattened views for the checks below
   assign pendNow = {st.grp0, st.grp1};
   assign setAll  = {setGrp0, setGrp1};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st      <= '0;
         st.grp0 <= `IRL_GRP_RESET;
         st.grp1 <= `IRL_GRP_RESET;
         st.edgeSel <= `IRL_CFG_RESET;
         st.anyEdge <= `IRL_CFG_RESET;
      end else begin
         st <= nx;
      end
   end

   assign vecReq  = st.vecValid;
   assign vecIdx  = st.vecIdx;
   assign trapOut = st.trap;
   assign irq     = st.irq;

   // Watchdog clearing is a software loop on the reset status side nothing here

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_timer_one_set: assert property (timerOneReq |=> st.grp0[`IRL_G0_T1_BIT])
      else $error("timer one request not latched");
   a_converter_set: assert property (converterReq |=> st.grp0[`IRL_G0_ADC_BIT] && vecReq == st.gie)
      else $error("converter request not latched at bit 0");
   a_pin_event_set: assert property ((|pinEvent) |=> ((st.grp1 & $past(pinEvent)) == $past(pinEvent)))
      else $error("pin event not latched in group one");
   a_vector_gate: assert property (vecReq |-> st.gie && (|{st.grp0, st.grp1}))
      else $error("vector offered without enable or pending bit");
   a_vector_source: assert property (vecReq |-> pendNow[vecIdx])
      else $error("vector index names an idle bit");
   a_reserved_zero: assert property ((st.grp0 & `IRL_G0_RSVD_MASK) == 8'h00)
      else $error("reserved group zero bit set");
   a_reset_clear: assert property ($rose(rst_n) |-> st.grp0 == 8'h00 && st.grp1 == 8'h00 && !vecReq)
      else $error("request groups not clear after reset");
   a_ack_clears: assert property ((ackTaken && !wrFire && !setAll[st.vecIdx])
      |=> !pendNow[$past(st.vecIdx)])
      else $error("taken vector did not clear its bit");
   a_trap_bypass: assert property (wdtTrapReq |=> trapOut[0] && $stable(st.grp0) || $past(|setGrp0)
      || $past(wrFire) || $past(ackTaken))
      else $error("watchdog trap not passed or touched group zero");
   a_ack_moves_on: assert property ((ackTaken && !wrFire && !(|setAll))
      |=> !vecReq || vecIdx != $past(st.vecIdx))
      else $error("taken vector offered again");

   // Per-source latching; each source is checked alone since the bench pulses only a few together
   a_timer_zero_set: assert property (timerZeroReq |=> st.grp0[`IRL_G0_T0_BIT])
      else $error("timer zero request not latched");
   a_serial_rx_set: assert property (serialRxReq |=> st.grp0[`IRL_G0_RX_BIT])
      else $error("receiver request not latched at bit 4");
   a_serial_tx_set: assert property (serialTxReq |=> st.grp0[`IRL_G0_TX_BIT])
      else $error("transmitter request not latched at bit 3");
   a_comparator_set: assert property (comparatorReq |=> st.grp1[`IRL_G1_CMP_BIT])
      else $error("comparator request not latched at bit 6");
   a_shared_set: assert property (pin7SharedReq |=> st.grp1[`IRL_G1_SHARED_BIT])
      else $error("shared request not latched at bit 7");
   a_polled_quiet: assert property (!st.gie |-> !vecReq)
      else $error("vector offered while interrupts are disabled");
   a_vector_offer: assert property (st.gie && (|pendNow) |-> vecReq)
      else $error("pending request not offered");
   a_idle_index: assert property (!vecReq |-> vecIdx == 4'h0)
      else $error("vector index moves with nothing offered");
   a_trap_follow: assert property (1'b1 |=> trapOut == $past({oscWdtFailReq, oscPrimFailReq, wdtTrapReq}))
      else $error("trap output does not follow its inputs");
   // Event flags feed irq; a missed flag would hide a request from a masked-in handler
   a_status_grp0: assert property ((|setGrp0) |=> st.status[`IRL_ST_G0_BIT])
      else $error("group zero event not flagged");
   a_status_grp1: assert property ((|setGrp1) |=> st.status[`IRL_ST_G1_BIT])
      else $error("group one event not flagged");
   a_irq_masked: assert property (!(|st.mask) |-> !irq)
      else $error("interrupt raised with every source masked");

endmodule
